// ---- design/casf_pkg.sv ----
// Purpose: Shared constants for the ALU status word block
// Assumes: APB slave, 32-bit data, 16-bit registers in the low half
// Notes: Offsets are byte addresses of aligned words
package casf_pkg;
	localparam int APB_AW = 8;
	localparam int WORD_W = 16;
	// Register byte offsets
	localparam logic [APB_AW-1:0] STATUS_OFS = 8'h00;
	localparam logic [APB_AW-1:0] CORE_CTRL_OFS = 8'h04;
	// Status word field positions
	localparam int DIGIT_CARRY_BIT = 8;
	localparam int PRIO_LSB = 5;
	localparam int PRIO_MSB = 7;
	localparam int REPEAT_BIT = 4;
	localparam int NEG_BIT = 3;
	localparam int OVERFLOW_BIT = 2;
	localparam int ZERO_BIT = 1;
	localparam int CARRY_BIT = 0;
	// Core control word field position
	localparam int PRIO_TOP_POS = 3;
	// Reset values
	localparam logic [WORD_W-1:0] STATUS_RST = 16'h0000;
	localparam logic [WORD_W-1:0] CORE_CTRL_RST = 16'h0000;
	// Priority field value that shuts out user interrupts
	localparam logic [2:0] PRIO_ALL_ONES = 3'h7;
	// Flag enable vector positions for an ALU operation
	localparam int FEN_CARRY = 0;
	localparam int FEN_ZERO = 1;
	localparam int FEN_OVERFLOW = 2;
	localparam int FEN_NEG = 3;
	localparam int FEN_DIGIT = 4;
	localparam int FEN_W = 5;
	// APB slave phase, Gray coded
	typedef enum logic [1:0]
	{
		APB_IDLE = 2'b00,
		APB_ACCESS = 2'b01
	} casf_apb_e;
endpackage

// ---- design/casf_alu_flags.sv ----
// Purpose: Computes sum and arithmetic flags of one ALU operation
// Assumes: Subtract is a + ~b + carry in, carry set means no borrow
// Notes: Pure combinational; byte mode works on the low eight bits
`timescale 1ns/1ns
`default_nettype none
module casf_alu_flags
(
	input wire logic [15:0] opa,
	input wire logic [15:0] opb,
	input wire logic cin,
	input wire logic sub,
	input wire logic byte_mode,
	output logic [15:0] result,
	output logic digit_carry,
	output logic neg,
	output logic overflow,
	output logic zero,
	output logic carry
);
	logic [15:0] b_eff;
	logic [4:0] nib_sum;
	logic [8:0] byte_sum;
	logic [16:0] word_sum;

	// Three adder widths give the nibble, byte and word carry-outs
	always_comb
	begin
		b_eff = sub ? ~opb : opb;
		nib_sum = {1'b0, opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		byte_sum = {1'b0, opa[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
		word_sum = {1'b0, opa} + {1'b0, b_eff} + {16'h0000, cin};
		if (byte_mode)
		begin
			result = {8'h00, byte_sum[7:0]};
			carry = byte_sum[8]; // see [RULE9]
			digit_carry = nib_sum[4]; // see [RULE1]
			neg = byte_sum[7]; // see [RULE11]
			overflow = (opa[7] == b_eff[7]) && (byte_sum[7] != opa[7]); // see [RULE6]
			zero = (byte_sum[7:0] == 8'h00);
		end
		else
		begin
			result = word_sum[15:0];
			carry = word_sum[16]; // see [RULE9]
			digit_carry = byte_sum[8]; // see [RULE1]
			neg = word_sum[15]; // see [RULE11]
			overflow = (opa[15] == b_eff[15]) && (word_sum[15] != opa[15]); // see [RULE6]
			zero = (word_sum[15:0] == 16'h0000);
		end
	end
endmodule
`default_nettype wire

// ---- design/casf_prio_level.sv ----
// Purpose: Forms the four-bit CPU priority level from its two parts
// Assumes: Field and top bit are next-state values of registers on the same clock
// Notes: Combinational; the caller registers the outputs
`timescale 1ns/1ns
`default_nettype none
module casf_prio_level
	import casf_pkg::*;
(
	input wire logic [2:0] field,
	input wire logic top,
	output logic [3:0] level,
	output logic user_off
);
	// Plain binary level, top bit lifts 0..7 to 8..15
	always_comb
	begin
		level = {top, field}; // see [RULE3] see [RULE4]
		user_off = (field == PRIO_ALL_ONES); // see [RULE2]
	end
endmodule
`default_nettype wire

// ---- design/casf_status_top.sv ----
// Purpose: ALU status word with priority field, reached over APB
// Assumes: ALU operation inputs and repeat_busy come from pclk logic
// Notes: An ALU operation wins over a software write to the same flag, except a zero flag held by op_z_keep on a zero result takes the write
//
// How it works
// [RULE1] Digit carry is carry out of bit 3 (byte) or bit 7 (word).
// [RULE2] Priority field bits 7..5 is CPU level; all ones disables user interrupts.
// [RULE3] Priority field is a plain binary level number, 000 to 111.
// [RULE4] Top priority bit sits above the field, making levels 8 to 15.
// [RULE5] Bit 4 is read-only and high while a repeat loop runs.
// [RULE6] Bit 2 shows signed two's-complement overflow of the last operation.
// [RULE7] Zero flag stays set until an affecting operation gives nonzero.
// [RULE8] Zero flag clears when the latest affecting operation gives nonzero.
// [RULE9] Bit 0 shows carry out of the result's most significant bit.
// [RULE10] Bits 15..9 read zero and ignore writes.
// [RULE11] Bit 3 shows a negative result, clear for zero or positive.
// [RULE12] Every implemented status bit clears on reset.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module casf_status_top
	import casf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [casf_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_valid,
	input wire logic op_sub,
	input wire logic op_byte,
	input wire logic op_cin,
	input wire logic op_z_keep,
	input wire logic [casf_pkg::FEN_W-1:0] op_flag_en,
	input wire logic [15:0] op_a,
	input wire logic [15:0] op_b,
	input wire logic repeat_busy,
	input wire logic prio_wr_lock,
	output logic [15:0] op_result,
	output logic [15:0] status_word,
	output logic [3:0] cpu_level,
	output logic user_int_off
);
	import casf_pkg::*;

	// Status word fields
	logic digit_carry_flag_q;
	logic digit_carry_flag_d;
	logic [2:0] cpu_priority_field_q;
	logic [2:0] cpu_priority_field_d;
	logic repeat_active_flag_q;
	logic repeat_active_flag_d;
	logic neg_flag_q;
	logic neg_flag_d;
	logic signed_overflow_flag_q;
	logic signed_overflow_flag_d;
	logic zero_flag_q;
	logic zero_flag_d;
	logic carry_flag_q;
	logic carry_flag_d;
	// Core control word field
	logic priority_top_bit_q;
	logic priority_top_bit_d;
	// Registered outputs
	logic [15:0] op_result_q;
	logic [15:0] op_result_d;
	logic [15:0] status_word_q;
	logic [15:0] status_word_d;
	logic [3:0] cpu_level_q;
	logic [3:0] cpu_level_d;
	logic user_int_off_q;
	logic user_int_off_d;
	// APB slave state
	casf_apb_e apb_state_q;
	casf_apb_e apb_state_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	// Decode and datapath nets
	logic hit_status;
	logic hit_core;
	logic setup_phase;
	logic access_done;
	logic sw_write;
	logic [15:0] read_word;
	logic [15:0] alu_result;
	logic alu_digit;
	logic alu_neg;
	logic alu_overflow;
	logic alu_zero;
	logic alu_carry;
	logic [3:0] level_next;
	logic user_off_next;

	// Adder and flag generation for the current operation
	casf_alu_flags u_flags
	(
		.opa(op_a),
		.opb(op_b),
		.cin(op_cin),
		.sub(op_sub),
		.byte_mode(op_byte),
		.result(alu_result),
		.digit_carry(alu_digit),
		.neg(alu_neg),
		.overflow(alu_overflow),
		.zero(alu_zero),
		.carry(alu_carry)
	);

	// Level is formed from next values so it lines up with the word
	casf_prio_level u_prio
	(
		.field(cpu_priority_field_d),
		.top(priority_top_bit_d),
		.level(level_next),
		.user_off(user_off_next)
	);

	// Address decode; anything else answers with an error
	always_comb
	begin
		hit_status = (paddr == STATUS_OFS);
		hit_core = (paddr == CORE_CTRL_OFS);
		setup_phase = psel && !penable && (apb_state_q == APB_IDLE);
		access_done = psel && penable && pready_q && (apb_state_q == APB_ACCESS);
		sw_write = access_done && pwrite && !pslverr_q;
	end

	// Read mux; unimplemented bits come back as zero
	always_comb
	begin
		read_word = 16'h0000;
		if (hit_status)
		begin
			read_word = status_word_q; // see [RULE10]
		end
		else if (hit_core)
		begin
			read_word[PRIO_TOP_POS] = priority_top_bit_q;
		end
	end

	// APB phases: one setup, one access cycle with pready high
	always_comb
	begin
		apb_state_d = apb_state_q;
		prdata_d = prdata_q;
		pready_d = pready_q;
		pslverr_d = pslverr_q;
		case (apb_state_q)
			APB_IDLE:
			begin
				if (setup_phase)
				begin
					apb_state_d = APB_ACCESS;
					pready_d = 1'b1;
					pslverr_d = !(hit_status || hit_core);
					// Read data is captured at setup, a same-cycle flag change is missed
					prdata_d = pwrite ? 32'h0000_0000 : {16'h0000, read_word};
				end
			end
			APB_ACCESS:
			begin
				// Leave after the handshake edge, or if the master drops the transfer
				apb_state_d = APB_IDLE;
				pready_d = 1'b0;
				pslverr_d = 1'b0;
				prdata_d = 32'h0000_0000;
			end
			default:
			begin
				apb_state_d = APB_IDLE;
				pready_d = 1'b0;
				pslverr_d = 1'b0;
				prdata_d = 32'h0000_0000;
			end
		endcase
	end

	// Flag update: software write first, then the ALU overrides its flags
	always_comb
	begin
		digit_carry_flag_d = digit_carry_flag_q;
		cpu_priority_field_d = cpu_priority_field_q;
		neg_flag_d = neg_flag_q;
		signed_overflow_flag_d = signed_overflow_flag_q;
		zero_flag_d = zero_flag_q;
		carry_flag_d = carry_flag_q;
		priority_top_bit_d = priority_top_bit_q;
		op_result_d = op_result_q;
		// Repeat flag follows the loop sequencer, software cannot write it
		repeat_active_flag_d = repeat_busy; // see [RULE5]
		if (sw_write && hit_status)
		begin
			// Upper byte lane carries only the digit carry bit
			if (pstrb[1])
			begin
				digit_carry_flag_d = pwdata[DIGIT_CARRY_BIT]; // see [RULE10]
			end
			if (pstrb[0])
			begin
				// Nesting lock freezes the priority field against writes
				if (!prio_wr_lock)
				begin
					cpu_priority_field_d = pwdata[PRIO_MSB:PRIO_LSB]; // see [RULE2]
				end
				neg_flag_d = pwdata[NEG_BIT];
				signed_overflow_flag_d = pwdata[OVERFLOW_BIT];
				zero_flag_d = pwdata[ZERO_BIT];
				carry_flag_d = pwdata[CARRY_BIT];
			end
		end
		if (sw_write && hit_core && pstrb[0])
		begin
			priority_top_bit_d = pwdata[PRIO_TOP_POS]; // see [RULE4]
		end
		if (op_valid)
		begin
			op_result_d = alu_result;
			if (op_flag_en[FEN_DIGIT])
			begin
				digit_carry_flag_d = alu_digit; // see [RULE1]
			end
			if (op_flag_en[FEN_NEG])
			begin
				neg_flag_d = alu_neg; // see [RULE11]
			end
			if (op_flag_en[FEN_OVERFLOW])
			begin
				signed_overflow_flag_d = alu_overflow; // see [RULE6]
			end
			if (op_flag_en[FEN_CARRY])
			begin
				carry_flag_d = alu_carry; // see [RULE9]
			end
			if (op_flag_en[FEN_ZERO])
			begin
				// Multi-word ops keep a set flag on a zero part result
				if (!alu_zero)
				begin
					zero_flag_d = 1'b0; // see [RULE8]
				end
				else if (!op_z_keep)
				begin
					zero_flag_d = 1'b1; // see [RULE7]
				end
			end
		end
	end

	// Assemble the visible word and the priority outputs
	always_comb
	begin
		status_word_d = STATUS_RST; // see [RULE10]
		status_word_d[DIGIT_CARRY_BIT] = digit_carry_flag_d;
		status_word_d[PRIO_MSB:PRIO_LSB] = cpu_priority_field_d;
		status_word_d[REPEAT_BIT] = repeat_active_flag_d;
		status_word_d[NEG_BIT] = neg_flag_d;
		status_word_d[OVERFLOW_BIT] = signed_overflow_flag_d;
		status_word_d[ZERO_BIT] = zero_flag_d;
		status_word_d[CARRY_BIT] = carry_flag_d;
		cpu_level_d = level_next;
		user_int_off_d = user_off_next;
	end

	// Flag and output registers, all cleared at reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			digit_carry_flag_q <= STATUS_RST[DIGIT_CARRY_BIT]; // see [RULE12]
			cpu_priority_field_q <= STATUS_RST[PRIO_MSB:PRIO_LSB];
			repeat_active_flag_q <= STATUS_RST[REPEAT_BIT];
			neg_flag_q <= STATUS_RST[NEG_BIT];
			signed_overflow_flag_q <= STATUS_RST[OVERFLOW_BIT];
			zero_flag_q <= STATUS_RST[ZERO_BIT];
			carry_flag_q <= STATUS_RST[CARRY_BIT];
			priority_top_bit_q <= CORE_CTRL_RST[PRIO_TOP_POS];
			op_result_q <= 16'h0000;
			status_word_q <= STATUS_RST;
			cpu_level_q <= 4'h0;
			user_int_off_q <= 1'b0;
		end
		else
		begin
			digit_carry_flag_q <= digit_carry_flag_d;
			cpu_priority_field_q <= cpu_priority_field_d;
			repeat_active_flag_q <= repeat_active_flag_d;
			neg_flag_q <= neg_flag_d;
			signed_overflow_flag_q <= signed_overflow_flag_d;
			zero_flag_q <= zero_flag_d;
			carry_flag_q <= carry_flag_d;
			priority_top_bit_q <= priority_top_bit_d;
			op_result_q <= op_result_d;
			status_word_q <= status_word_d;
			cpu_level_q <= cpu_level_d;
			user_int_off_q <= user_int_off_d;
		end
	end

	// APB registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_state_q <= APB_IDLE;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			apb_state_q <= apb_state_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign op_result = op_result_q;
	assign status_word = status_word_q;
	assign cpu_level = cpu_level_q;
	assign user_int_off = user_int_off_q;
endmodule
`default_nettype wire

// ---- sim/casf_status_monitor.sv ----
// Purpose: Concurrent checks on the status word block outputs
// Assumes: All ports on pclk; flag math checked for word adds
// Notes: Sees only top ports, so the top priority bit is not checked
`timescale 1ns/1ns
`default_nettype none
module casf_status_monitor
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic op_valid,
	input wire logic op_sub,
	input wire logic op_byte,
	input wire logic op_cin,
	input wire logic op_z_keep,
	input wire logic [casf_pkg::FEN_W-1:0] op_flag_en,
	input wire logic [15:0] op_a,
	input wire logic [15:0] op_b,
	input wire logic repeat_busy,
	input wire logic [15:0] op_result,
	input wire logic [15:0] status_word,
	input wire logic [3:0] cpu_level,
	input wire logic user_int_off
);
	import casf_pkg::*;
	logic [16:0] sum_w;
	logic [8:0] sum_lo;
	logic add_w;
	logic ovf_w;
	// Own reference adder, so a shared slip in the design cannot hide
	assign sum_w = {1'h0, op_a} + {1'h0, op_b} + {16'h0, op_cin};
	assign sum_lo = {1'h0, op_a[7:0]} + {1'h0, op_b[7:0]} + {8'h0, op_cin};
	assign add_w = op_valid && !op_sub && !op_byte;
	assign ovf_w = (op_a[15] == op_b[15]) && (sum_w[15] != op_a[15]);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_reset_clear: assert property (disable iff (1'h0)
		!presetn |-> status_word == 16'h0)
		else $error("status not clear in reset");
	a_upper_zero: assert property (status_word[15:9] == 7'h0)
		else $error("upper status bits set");
	a_level_field: assert property (cpu_level[2:0] == status_word[7:5])
		else $error("level does not match field");
	a_user_off: assert property (
		user_int_off == (status_word[7:5] == PRIO_ALL_ONES))
		else $error("user interrupt off wrong");
	a_repeat_track: assert property ($past(presetn) |->
		status_word[4] == $past(repeat_busy))
		else $error("repeat flag does not track");
	a_zero_flag: assert property (op_valid && op_flag_en[FEN_ZERO] |=>
		status_word[1] == (op_result == 16'h0 && (!$past(op_z_keep) || $past(status_word[1]))))
		else $error("zero flag wrong");
	a_carry_out: assert property (add_w && op_flag_en[FEN_CARRY] |=>
		status_word[0] == $past(sum_w[16]))
		else $error("carry flag wrong");
	a_neg_flag: assert property (op_valid && !op_byte && op_flag_en[FEN_NEG] |=>
		status_word[3] == op_result[15])
		else $error("negative flag wrong");
	a_signed_ovf: assert property (add_w && op_flag_en[FEN_OVERFLOW] |=>
		status_word[2] == $past(ovf_w))
		else $error("overflow flag wrong");
	a_digit_carry: assert property (add_w && op_flag_en[FEN_DIGIT] |=>
		status_word[8] == $past(sum_lo[8]))
		else $error("digit carry wrong");
endmodule
bind casf_status_top casf_status_monitor u_mon (.pclk(pclk), .presetn(presetn), .op_valid(op_valid),
	.op_sub(op_sub), .op_byte(op_byte), .op_cin(op_cin), .op_z_keep(op_z_keep),
	.op_flag_en(op_flag_en), .op_a(op_a), .op_b(op_b), .repeat_busy(repeat_busy),
	.op_result(op_result), .status_word(status_word), .cpu_level(cpu_level),
	.user_int_off(user_int_off));
`default_nettype wire

// ---- sim/test_cpu_alu_status_flags.sv ----
// Purpose: Self-checking bench for the ALU status word block
// Assumes: Zero-wait APB slave; one ALU op at a time
// Notes: Byte lanes and flag enables stay all on except in their own hand tests
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, s) \
	begin \
		total_checks++; \
		if ((s) !== (e)) \
		begin \
			n_fail++; \
			$display("FAIL %s exp %h got %h", n, e, s); \
		end \
	end
module test_cpu_alu_status_flags;
	import casf_pkg::*;
	typedef struct packed
	{
		logic s;
		logic y;
		logic c;
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] r;
		logic [4:0] f;
	} casf_row_s;
	// Flags column is digit carry, negative, overflow, zero, carry
	casf_row_s rows [8] = '{'{1'h0, 1'h0, 1'h0, 16'h7fff, 16'h1, 16'h8000, 5'h1c},
		'{1'h0, 1'h0, 1'h0, 16'hffff, 16'h1, 16'h0, 5'h13},
		'{1'h1, 1'h0, 1'h1, 16'h5, 16'h5, 16'h0, 5'h13},
		'{1'h1, 1'h0, 1'h1, 16'h0, 16'h1, 16'hffff, 5'h08},
		'{1'h0, 1'h1, 1'h0, 16'hf, 16'h1, 16'h10, 5'h10},
		'{1'h0, 1'h1, 1'h0, 16'h80, 16'h80, 16'h0, 5'h07},
		'{1'h1, 1'h1, 1'h1, 16'h80, 16'h1, 16'h7f, 5'h05},
		'{1'h0, 1'h0, 1'h1, 16'h1234, 16'h0, 16'h1235, 5'h00}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic op_valid, op_sub, op_byte, op_cin, op_z_keep, repeat_busy, prio_wr_lock, user_int_off;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, cpu_level, i;
	logic [4:0] op_flag_en;
	logic [15:0] op_a, op_b, op_result, status_word;
	int n_fail = 0;
	int total_checks = 0;
	casf_status_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_sub(op_sub),
		.op_byte(op_byte), .op_cin(op_cin), .op_z_keep(op_z_keep), .op_flag_en(op_flag_en),
		.op_a(op_a), .op_b(op_b), .repeat_busy(repeat_busy), .prio_wr_lock(prio_wr_lock),
		.op_result(op_result), .status_word(status_word), .cpu_level(cpu_level),
		.user_int_off(user_int_off));
	// Free-running 125 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	task automatic test_done;
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One transfer; the request is held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(negedge pclk);
	endtask
	// One-cycle ALU op; flags are read at the following falling edge
	task automatic op(input logic s, y, c, k, input logic [15:0] a, b);
		@(posedge pclk);
		op_valid <= 1'h1;
		op_sub <= s;
		op_byte <= y;
		op_cin <= c;
		op_z_keep <= k;
		op_a <= a;
		op_b <= b;
		@(posedge pclk);
		op_valid <= 1'h0;
		@(negedge pclk);
	endtask
	// Hang guard, far beyond the hundred or so cycles the run needs
	initial
	begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		test_done;
	end
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, op_valid, op_sub, op_byte} = '0;
		{op_cin, op_z_keep, op_a, op_b, repeat_busy, prio_wr_lock} = '0;
		op_flag_en = 5'h1f;
		pstrb = 4'hf;
		repeat (20) @(posedge pclk);
		`CK("reset", 16'h0, status_word)
		presetn <= 1'h1;
		for (i = 4'h0; i < 4'h8; i++)
		begin
			op(rows[i].s, rows[i].y, rows[i].c, 1'h0, rows[i].a, rows[i].b);
			`CK("result", rows[i].r, op_result)
			`CK("dc n", rows[i].f[4:3], {status_word[8], status_word[3]})
			`CK("v z c", rows[i].f[2:0], status_word[2:0])
		end
		op(1'h0, 1'h0, 1'h0, 1'h0, 16'h0, 16'h0);
		op(1'h0, 1'h0, 1'h0, 1'h1, 16'h0, 16'h0);
		`CK("z sticky", 1'h1, status_word[1])
		op(1'h0, 1'h0, 1'h0, 1'h1, 16'h1, 16'h0);
		`CK("z clear", 1'h0, status_word[1])
		op(1'h0, 1'h0, 1'h0, 1'h1, 16'h0, 16'h0);
		`CK("z kept", 1'h0, status_word[1])
		// Only the carry enable is on, so zero and digit carry must hold
		@(posedge pclk);
		op_flag_en <= 5'h01;
		op(1'h0, 1'h0, 1'h0, 1'h0, 16'hffff, 16'h1);
		`CK("masked", 5'h01, {status_word[8], status_word[3:0]})
		@(posedge pclk);
		op_flag_en <= 5'h1f;
		apb(1'h1, STATUS_OFS, 16'hffff);
		apb(1'h0, STATUS_OFS, 16'h0);
		`CK("status rd", 32'h01ef, rd)
		`CK("user off", 1'h1, user_int_off)
		apb(1'h1, CORE_CTRL_OFS, 16'h8);
		for (i = 4'h0; i < 4'h8; i++)
		begin
			apb(1'h1, STATUS_OFS, {8'h0, i[2:0], 5'h0});
			`CK("level", {1'h1, i[2:0]}, cpu_level)
			`CK("user off", i == 4'h7, user_int_off)
		end
		apb(1'h0, 8'h08, 16'h0);
		`CK("unmapped", {1'h1, 32'h0}, {er, rd})
		// Op and write on one edge: op flags win, the field still lands
		fork
			apb(1'h1, STATUS_OFS, 16'h00af);
			begin
				@(posedge pclk);
				op(1'h0, 1'h0, 1'h0, 1'h0, 16'h1, 16'h1);
			end
		join
		`CK("op beats write", 16'h00a0, status_word)
		@(posedge pclk);
		repeat_busy <= 1'h1;
		apb(1'h1, STATUS_OFS, 16'h00e0);
		`CK("repeat", 1'h1, status_word[4])
		@(posedge pclk);
		repeat_busy <= 1'h0;
		prio_wr_lock <= 1'h1;
		apb(1'h1, STATUS_OFS, 16'h0);
		`CK("repeat", 1'h0, status_word[4])
		`CK("locked", 3'h7, status_word[7:5])
		// Upper lane only: digit carry lands, bits 15..9 and the low byte do not
		@(posedge pclk);
		prio_wr_lock <= 1'h0;
		pstrb <= 4'h2;
		apb(1'h1, STATUS_OFS, 16'hff1f);
		`CK("upper lane", 16'h01e0, status_word)
		@(posedge pclk);
		presetn <= 1'h0;
		@(negedge pclk);
		`CK("reset", 20'h0, {status_word, cpu_level})
		// Second release: the first setup starts one cycle after presetn rises
		@(posedge pclk);
		presetn <= 1'h1;
		pstrb <= 4'hf;
		apb(1'h1, STATUS_OFS, 16'h0001);
		`CK("after reset", 20'h00010, {status_word, cpu_level})
		test_done;
	end
endmodule
`default_nettype wire
